// ### design/aaba_adder.sv
`timescale 1ns/1ps

module aaba_adder (
    input  wire aaba_pkg::aaba_byte_t a,
    input  wire aaba_pkg::aaba_byte_t b,
    input  wire logic                 cin,
    output aaba_pkg::aaba_byte_t      sum,
    output logic                      digit_carry,
    output logic                      carry,
    output logic                      zero
);
    import aaba_pkg::*;

    logic [4:0] low_nib;
    logic [4:0] high_nib;

    // nibble-split add so the carry out of bit 3 is visible
    always_comb begin
        low_nib     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        high_nib    = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low_nib[4]};
        sum         = {high_nib[3:0], low_nib[3:0]};
        digit_carry = low_nib[4];
        carry       = high_nib[4];
        zero        = ({high_nib[3:0], low_nib[3:0]} == 8'h00);
    end

endmodule : aaba_adder

// ### design/aaba_alu.sv
`timescale 1ns/1ps
`include "aaba_defines.svh"

// Functional notes
// (RULE1) add_reg_with_carry forms register plus accumulator plus carry, sets zero, digit carry and carry, in one cycle.
// (RULE2) for register-source ops a destination bit of 0 writes the accumulator and 1 writes the addressed register.
// (RULE3) add_reg adds accumulator and register ignoring the carry, sets zero, digit carry and carry, in one cycle.
// (RULE4) add_imm_with_carry adds accumulator, an 8-bit immediate and carry into the accumulator, updating all three flags.
// (RULE5) add_imm adds accumulator and an 8-bit immediate without carry into the accumulator, all flags, one cycle.
// (RULE6) and_reg ands accumulator and register, routes by destination bit, touches only zero, in one cycle.
// (RULE7) bit_clear_op forces bit 0..7 of the register to zero, other bits and all flags unchanged, one cycle.
// (RULE8) the timeout status flag is 1 after reset and after watchdog_clear_op or sleep, and 0 on watchdog time-out.
// (RULE9) zero is set when the 8-bit result is zero, and digit carry takes the carry out of bit 3 on additions.
// (RULE10) bit_set_op forces bit 0..7 of the register to one, no flags touched, one cycle.
module aaba_alu (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  wdt_timeout,
    output logic                       irq,
    output aaba_pkg::aaba_byte_t       accumulator,
    output logic                       zero_flag,
    output logic                       digit_carry_flag,
    output logic                       carry_flag,
    output logic                       timeout_status_flag
);
    import aaba_pkg::*;

    // register file of the addressed operands
    aaba_byte_t       regfile [0:63];

    // apb phase decode
    logic             setup_phase;
    logic             access_phase;
    logic             wr_access;
    logic             cmd_fire;

    // command word fields
    aaba_op_e         cmd_op;
    logic             cmd_dest;
    logic [2:0]       cmd_bit;
    aaba_radr_t       cmd_reg;
    aaba_byte_t       cmd_imm;

    // operand select and adder path
    aaba_byte_t       reg_src;
    aaba_byte_t       add_b;
    logic             add_cin;
    aaba_byte_t       add_sum;
    logic             add_dc;
    logic             add_c;
    logic             add_z;
    aaba_byte_t       and_res;
    aaba_byte_t       bit_mask;

    // next values of the datapath state
    aaba_byte_t       next_accumulator;
    logic             next_zero_flag;
    logic             next_digit_carry_flag;
    logic             next_carry_flag;
    logic             next_timeout_status_flag;

    // sticky interrupt state
    logic [2:0]       irq_stat;
    logic [2:0]       irq_mask;
    logic [2:0]       next_irq_stat;
    logic [2:0]       next_irq_mask;
    logic             next_irq;

    // register file write port
    logic             rf_we;
    aaba_radr_t       rf_waddr;
    aaba_byte_t       rf_wdata;

    // bus answer and raw interrupt events
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    logic [2:0]       irq_events;

    // decode of a control register offset, used for reads and writes
    function automatic logic ctl_hit(input logic [11:0] addr, input logic [11:0] off);
        ctl_hit = (addr == off);
    endfunction : ctl_hit

    // decode of the register file window
    function automatic logic rf_hit(input logic [11:0] addr);
        rf_hit = (addr[11:8] == `AABA_RF_PAGE) && (addr[1:0] == 2'b00);
    endfunction : rf_hit

    // any mapped address
    function automatic logic mapped(input logic [11:0] addr);
        mapped = ctl_hit(addr, `AABA_OFF_CMD) || ctl_hit(addr, `AABA_OFF_ACC)
              || ctl_hit(addr, `AABA_OFF_STATUS) || ctl_hit(addr, `AABA_OFF_IRQ_STAT)
              || ctl_hit(addr, `AABA_OFF_IRQ_MASK) || rf_hit(addr);
    endfunction : mapped

    // apb phase decode and command fields
    always_comb begin
        setup_phase  = psel && !penable;
        access_phase = psel && penable && pready;
        wr_access    = access_phase && pwrite && mapped(paddr) && pstrb[0];
        cmd_fire     = wr_access && ctl_hit(paddr, `AABA_OFF_CMD);
        cmd_op       = aaba_op_e'(pwdata[`AABA_CMD_OP_MSB:`AABA_CMD_OP_LSB]);
        cmd_dest     = pwdata[`AABA_CMD_DEST];
        cmd_bit      = pwdata[`AABA_CMD_BIT_MSB:`AABA_CMD_BIT_LSB];
        cmd_reg      = pwdata[`AABA_CMD_REG_MSB:`AABA_CMD_REG_LSB];
        cmd_imm      = pwdata[`AABA_CMD_IMM_MSB:`AABA_CMD_IMM_LSB];
        reg_src      = regfile[cmd_reg];
        bit_mask     = 8'h01 << cmd_bit;
        and_res      = accumulator & reg_src;
    end

    // adder operand select: immediate or register, carry in or not
    always_comb begin
        add_b   = ((cmd_op == AABA_OP_ADD_IMM) || (cmd_op == AABA_OP_ADC_IMM)) ? cmd_imm : reg_src;
        add_cin = 1'b0;                                  // see (RULE3) see (RULE5)
        if ((cmd_op == AABA_OP_ADC_REG) || (cmd_op == AABA_OP_ADC_IMM)) begin
            add_cin = carry_flag;                        // see (RULE1) see (RULE4)
        end
    end

    // shared 8-bit adder with the bit 3 carry split out
    aaba_adder u_adder (
        .a           (accumulator),
        .b           (add_b),
        .cin         (add_cin),
        .sum         (add_sum),
        .digit_carry (add_dc),
        .carry       (add_c),
        .zero        (add_z)
    );

    // operation execution and software writes to the datapath state
    always_comb begin
        next_accumulator         = accumulator;
        next_zero_flag           = zero_flag;
        next_digit_carry_flag    = digit_carry_flag;
        next_carry_flag          = carry_flag;
        next_timeout_status_flag = timeout_status_flag;
        rf_we                    = 1'b0;
        rf_waddr                 = cmd_reg;
        rf_wdata                 = reg_src;
        irq_events               = 3'h0;

        // a command word runs one operation at its access edge
        if (cmd_fire) begin
            irq_events[`AABA_IRQ_DONE] = 1'b1;
            case (cmd_op)
                // register add, routed by the destination bit
                AABA_OP_ADD_REG, AABA_OP_ADC_REG: begin
                    if (cmd_dest == `AABA_DEST_ACC) begin
                        next_accumulator = add_sum;      // see (RULE2)
                    end else begin
                        rf_we    = 1'b1;                 // see (RULE2)
                        rf_wdata = add_sum;
                    end
                    next_zero_flag        = add_z;       // see (RULE9) see (RULE1) see (RULE3)
                    next_digit_carry_flag = add_dc;      // see (RULE9)
                    next_carry_flag       = add_c;
                    irq_events[`AABA_IRQ_CARRY] = add_c;
                end
                // immediate add always lands in the accumulator
                AABA_OP_ADD_IMM, AABA_OP_ADC_IMM: begin
                    next_accumulator      = add_sum;     // see (RULE4) see (RULE5)
                    next_zero_flag        = add_z;       // see (RULE9)
                    next_digit_carry_flag = add_dc;      // see (RULE9)
                    next_carry_flag       = add_c;
                    irq_events[`AABA_IRQ_CARRY] = add_c;
                end
                // and touches only the zero flag
                AABA_OP_AND_REG: begin
                    if (cmd_dest == `AABA_DEST_ACC) begin
                        next_accumulator = and_res;      // see (RULE6) see (RULE2)
                    end else begin
                        rf_we    = 1'b1;                 // see (RULE6) see (RULE2)
                        rf_wdata = and_res;
                    end
                    next_zero_flag = (and_res == 8'h00); // see (RULE6) see (RULE9)
                end
                // bit ops leave every flag alone
                AABA_OP_BIT_CLEAR: begin
                    rf_we    = 1'b1;                     // see (RULE7)
                    rf_wdata = reg_src & ~bit_mask;
                end
                AABA_OP_BIT_SET: begin
                    rf_we    = 1'b1;                     // see (RULE10)
                    rf_wdata = reg_src | bit_mask;
                end
                // watchdog clear and sleep raise the timeout flag
                AABA_OP_WDT_CLEAR, AABA_OP_SLEEP: begin
                    next_timeout_status_flag = 1'b1;     // see (RULE8)
                end
                default: begin
                    next_accumulator = accumulator;
                end
            endcase
        end else if (wr_access && ctl_hit(paddr, `AABA_OFF_ACC)) begin
            next_accumulator = pwdata[7:0];
        end else if (wr_access && ctl_hit(paddr, `AABA_OFF_STATUS)) begin
            next_zero_flag        = pwdata[`AABA_ST_ZERO];
            next_digit_carry_flag = pwdata[`AABA_ST_DC];
            next_carry_flag       = pwdata[`AABA_ST_CARRY];
        end else if (wr_access && rf_hit(paddr)) begin
            rf_we    = 1'b1;
            rf_waddr = paddr[7:2];
            rf_wdata = pwdata[7:0];
        end

        // a time-out in the same cycle as a clear leaves the flag low
        if (wdt_timeout) begin
            next_timeout_status_flag   = 1'b0;           // see (RULE8)
            irq_events[`AABA_IRQ_WDT]  = 1'b1;
        end
    end

    // sticky interrupt status, write one to clear, events win
    always_comb begin
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr_access && ctl_hit(paddr, `AABA_OFF_IRQ_STAT)) begin
            next_irq_stat = irq_stat & ~pwdata[`AABA_IRQ_W-1:0];
        end
        if (wr_access && ctl_hit(paddr, `AABA_OFF_IRQ_MASK)) begin
            next_irq_mask = pwdata[`AABA_IRQ_W-1:0];
        end
        // a same-cycle event wins over the clear
        next_irq_stat = next_irq_stat | irq_events;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    // apb answer: read data latched in setup, ready in the access cycle
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pready  = setup_phase;
        next_pslverr = setup_phase && !mapped(paddr);
        // read word chosen at the setup edge
        if (setup_phase && !pwrite) begin
            if (ctl_hit(paddr, `AABA_OFF_ACC)) begin
                next_prdata = {24'h00_0000, accumulator};
            end else if (ctl_hit(paddr, `AABA_OFF_STATUS)) begin
                next_prdata = {28'h000_0000, timeout_status_flag, carry_flag,
                               digit_carry_flag, zero_flag};
            end else if (ctl_hit(paddr, `AABA_OFF_IRQ_STAT)) begin
                next_prdata = {29'h0000_0000, irq_stat};
            end else if (ctl_hit(paddr, `AABA_OFF_IRQ_MASK)) begin
                next_prdata = {29'h0000_0000, irq_mask};
            end else if (rf_hit(paddr)) begin
                next_prdata = {24'h00_0000, regfile[paddr[7:2]]};
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    // datapath, flag, interrupt and bus state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator         <= `AABA_ACC_RST;
            zero_flag           <= `AABA_FLAG_RST;
            digit_carry_flag    <= `AABA_FLAG_RST;
            carry_flag          <= `AABA_FLAG_RST;
            timeout_status_flag <= `AABA_TO_RST;         // see (RULE8)
            irq_stat            <= `AABA_IRQ_RST;
            irq_mask            <= `AABA_IRQ_RST;
            irq                 <= 1'b0;
            prdata              <= 32'h0000_0000;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
        end else begin
            accumulator         <= next_accumulator;
            zero_flag           <= next_zero_flag;
            digit_carry_flag    <= next_digit_carry_flag;
            carry_flag          <= next_carry_flag;
            timeout_status_flag <= next_timeout_status_flag;
            irq_stat            <= next_irq_stat;
            irq_mask            <= next_irq_mask;
            irq                 <= next_irq;
            prdata              <= next_prdata;
            pready              <= next_pready;
            pslverr             <= next_pslverr;
        end
    end

    // register file storage, one write port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // every byte reads zero after reset
            for (int i = 0; i < 64; i++) begin
                regfile[i] <= `AABA_RF_RST;
            end
        end else if (rf_we) begin
            regfile[rf_waddr] <= rf_wdata;
        end
    end

endmodule : aaba_alu

// ### design/aaba_defines.svh
`ifndef AABA_DEFINES_SVH
`define AABA_DEFINES_SVH

// register byte offsets, 12-bit apb address space
`define AABA_OFF_CMD        12'h000
`define AABA_OFF_ACC        12'h004
`define AABA_OFF_STATUS     12'h008
`define AABA_OFF_IRQ_STAT   12'h00c
`define AABA_OFF_IRQ_MASK   12'h010
`define AABA_RF_PAGE        4'h1

// command word fields
`define AABA_CMD_OP_MSB     3
`define AABA_CMD_OP_LSB     0
`define AABA_CMD_DEST       4
`define AABA_CMD_BIT_MSB    7
`define AABA_CMD_BIT_LSB    5
`define AABA_CMD_REG_MSB    13
`define AABA_CMD_REG_LSB    8
`define AABA_CMD_IMM_MSB    23
`define AABA_CMD_IMM_LSB    16

// status register fields
`define AABA_ST_ZERO        0
`define AABA_ST_DC          1
`define AABA_ST_CARRY       2
`define AABA_ST_TO          3

// interrupt status and mask fields
`define AABA_IRQ_DONE       0
`define AABA_IRQ_WDT        1
`define AABA_IRQ_CARRY      2
`define AABA_IRQ_W          3

// reset values
`define AABA_ACC_RST        8'h00
`define AABA_FLAG_RST       1'b0
`define AABA_TO_RST         1'b1
`define AABA_IRQ_RST        3'h0
`define AABA_RF_RST         8'h00

// destination select encoding
`define AABA_DEST_ACC       1'b0
`define AABA_DEST_REG       1'b1

`endif

// ### design/aaba_pkg.sv
package aaba_pkg;

    typedef logic [7:0] aaba_byte_t;
    typedef logic [5:0] aaba_radr_t;

    // operation codes of the command word
    typedef enum logic [3:0] {
        AABA_OP_NOP       = 4'b0000,
        AABA_OP_ADD_REG   = 4'b0001,
        AABA_OP_ADC_REG   = 4'b0010,
        AABA_OP_ADD_IMM   = 4'b0011,
        AABA_OP_ADC_IMM   = 4'b0100,
        AABA_OP_AND_REG   = 4'b0101,
        AABA_OP_BIT_CLEAR = 4'b0110,
        AABA_OP_BIT_SET   = 4'b0111,
        AABA_OP_WDT_CLEAR = 4'b1000,
        AABA_OP_SLEEP     = 4'b1001
    } aaba_op_e;

endpackage : aaba_pkg

// ### verif/aaba_alu_monitor.sv
`timescale 1ns/1ps

module aaba_alu_monitor (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 wdt_timeout,
    input wire logic                 irq,
    input wire aaba_pkg::aaba_byte_t accumulator,
    input wire logic                 zero_flag,
    input wire logic                 digit_carry_flag,
    input wire logic                 carry_flag,
    input wire logic                 timeout_status_flag
);
    import aaba_pkg::*;
    // command word accepted at the access edge
    wire       cmd_wr = psel & penable & pready & pwrite & (paddr == 12'h000) & pstrb[0];
    wire [3:0] op     = pwdata[3:0];
    wire [7:0] imm    = pwdata[23:16];
    wire       to_cmd = cmd_wr & ((op == 4'h8) | (op == 4'h9));

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not a one cycle answer");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    to_after_reset_a: assert property (!$past(presetn) |-> timeout_status_flag)
        else $error("timeout flag low after reset");
    to_clear_a: assert property (wdt_timeout |=> !timeout_status_flag)
        else $error("timeout flag kept after watchdog time-out");
    to_set_a: assert property ($rose(timeout_status_flag) |-> $past(to_cmd))
        else $error("timeout flag rose without clear or sleep");
    imm_sum_a: assert property (cmd_wr && op == 4'h3
        |=> {carry_flag, accumulator} == {1'b0, $past(accumulator)} + {1'b0, $past(imm)})
        else $error("immediate add result wrong");
    imm_carry_a: assert property (cmd_wr && op == 4'h4 |=> {carry_flag, accumulator} ==
        {1'b0, $past(accumulator)} + {1'b0, $past(imm)} + {8'h00, $past(carry_flag)})
        else $error("immediate add with carry result wrong");
    imm_zero_a: assert property (cmd_wr && (op == 4'h3 || op == 4'h4)
        |=> zero_flag == (accumulator == 8'h00))
        else $error("zero flag does not match result");
    and_keeps_a: assert property (cmd_wr && op == 4'h5
        |=> $stable({digit_carry_flag, carry_flag}))
        else $error("and changed digit carry or carry");
    bit_keeps_a: assert property (cmd_wr && (op == 4'h6 || op == 4'h7)
        |=> $stable({accumulator, zero_flag, digit_carry_flag, carry_flag}))
        else $error("bit op changed accumulator or flags");
endmodule : aaba_alu_monitor

bind aaba_alu aaba_alu_monitor i_aaba_alu_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_timeout(wdt_timeout), .irq(irq), .accumulator(accumulator),
    .zero_flag(zero_flag), .digit_carry_flag(digit_carry_flag), .carry_flag(carry_flag),
    .timeout_status_flag(timeout_status_flag));

// ### verif/tb.sv
`timescale 1ns/1ps

module tb;
    import aaba_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wdt_timeout, irq;
    logic        zero_flag, digit_carry_flag, carry_flag, timeout_status_flag, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [7:0]  v;
    aaba_byte_t  accumulator;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;

    aaba_alu i_aaba_alu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout), .irq(irq),
        .accumulator(accumulator), .zero_flag(zero_flag), .digit_carry_flag(digit_carry_flag),
        .carry_flag(carry_flag), .timeout_status_flag(timeout_status_flag));

    // 10 mhz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_sim;
        $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, then an idle cycle
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic op(input logic [3:0] o, input logic d, input logic [2:0] b,
                      input logic [5:0] r, input logic [7:0] i);
        wr(12'h000, {8'h00, i, 2'b00, r, b, d, o});
    endtask : op

    function automatic logic [11:0] ra(input logic [5:0] i);
        return {4'h1, i, 2'b00};
    endfunction : ra

    task automatic wdt_pulse;
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        @(posedge pclk);
    endtask : wdt_pulse

    initial begin
        {presetn, psel, penable, pwrite, wdt_timeout} = 5'h00;
        paddr  = 12'h000;
        pwdata = 32'h0;
        pstrb  = 4'hf;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(timeout_status_flag), 32'h1);
        rd(12'h008, 32'h8);
        rd(12'h010, 32'h0);
        rd(ra(6'd5), 32'h0);
        $display("reset test done");
        wr(12'h004, 32'h12);
        wr(12'h008, 32'h4);
        wr(ra(6'd3), 32'h34);
        op(4'h2, 1'b1, 3'd0, 6'd3, 8'h00);
        rd(ra(6'd3), 32'h47);
        rd(12'h004, 32'h12);
        rd(12'h008, 32'h8);
        wr(12'h008, 32'h4);
        op(4'h1, 1'b1, 3'd0, 6'd3, 8'h00);
        rd(ra(6'd3), 32'h59);
        rd(12'h008, 32'h8);
        op(4'h1, 1'b0, 3'd0, 6'd3, 8'h00);
        rd(12'h004, 32'h6b);
        rd(ra(6'd3), 32'h59);
        $display("register add test done");
        wr(12'h004, 32'hf8);
        op(4'h3, 1'b1, 3'd0, 6'd0, 8'h08);
        rd(12'h004, 32'h00);
        rd(12'h008, 32'hf);
        chk(32'({carry_flag, digit_carry_flag, zero_flag}), 32'h7);
        op(4'h4, 1'b0, 3'd0, 6'd0, 8'h0e);
        rd(12'h004, 32'h0f);
        rd(12'h008, 32'h8);
        op(4'h3, 1'b0, 3'd0, 6'd0, 8'h01);
        chk(32'(accumulator), 32'h10);
        rd(12'h008, 32'ha);
        $display("immediate add test done");
        wr(12'h008, 32'h6);
        wr(12'h004, 32'h5a);
        wr(ra(6'd4), 32'haf);
        op(4'h5, 1'b1, 3'd0, 6'd4, 8'h00);
        rd(ra(6'd4), 32'h0a);
        rd(12'h008, 32'he);
        wr(ra(6'd2), 32'ha5);
        op(4'h5, 1'b0, 3'd0, 6'd2, 8'h00);
        rd(12'h004, 32'h00);
        rd(12'h008, 32'hf);
        $display("and test done");
        // walk every bit position down, then back up
        v = 8'hff;
        wr(ra(6'd63), 32'hff);
        for (int b = 0; b < 8; b++) begin
            op(4'h6, 1'b0, 3'(b), 6'd63, 8'h00);
            v[b] = 1'b0;
            rd(ra(6'd63), 32'(v));
        end
        for (int b = 7; b >= 0; b--) begin
            op(4'h7, 1'b0, 3'(b), 6'd63, 8'h00);
            v[b] = 1'b1;
            rd(ra(6'd63), 32'(v));
        end
        rd(12'h008, 32'hf);
        $display("bit test done");
        rd(12'h00c, 32'h5);
        wr(12'h00c, 32'h7);
        wdt_pulse();
        chk(32'(timeout_status_flag), 32'h0);
        rd(12'h00c, 32'h2);
        chk(32'(irq), 32'h0);
        wr(12'h010, 32'h2);
        chk(32'(irq), 32'h1);
        wr(12'h00c, 32'h2);
        chk(32'(irq), 32'h0);
        op(4'h8, 1'b0, 3'd0, 6'd0, 8'h00);
        rd(12'h008, 32'hf);
        chk(32'(irq), 32'h0);
        wdt_pulse();
        op(4'h9, 1'b0, 3'd0, 6'd0, 8'h00);
        chk(32'(timeout_status_flag), 32'h1);
        $display("timeout test done");
        rd(12'h020, 32'h0);
        chk(32'(e), 32'h1);
        $display("unmapped test done");
        pstrb <= 4'he;
        wr(12'h004, 32'h55);
        pstrb <= 4'hf;
        chk(32'(accumulator), 32'h00);
        op(4'h0, 1'b1, 3'd0, 6'd63, 8'hff);
        rd(ra(6'd63), 32'hff);
        chk(32'(accumulator), 32'h00);
        $display("refused write and nop test done");
        wdt_pulse();
        chk(32'(timeout_status_flag), 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(timeout_status_flag), 32'h1);
        rd(ra(6'd63), 32'h0);
        $display("mid-run reset test done");
        end_sim();
    end
endmodule : tb
